// file: hw/flash_host_pkg.sv
package flash_host_pkg;

   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 5;
   localparam int ARM_TIME_MS = 1;
   localparam int ARM_CYCLES_DEF = ARM_TIME_MS * 1000000 / CLK_PERIOD_NS;
   localparam int BURST_TIMEOUT_US = 20;
   localparam int BURST_TIMEOUT_CYC = BURST_TIMEOUT_US * 1000 / CLK_PERIOD_NS;
   localparam int PROG_TIME_NS = 1000;
   localparam int PROG_CYC = (PROG_TIME_NS + CLK_PERIOD_NS - 1)
                             / CLK_PERIOD_NS;

   // ----------------------------------------
   // commands {p3[7],p3[6],p2[7],p2[6]}
   // ----------------------------------------
   localparam logic [3:0] CMD_ID = 4'h0;
   localparam logic [3:0] CMD_CHIP = 4'h1;
   localparam logic [3:0] CMD_BLOCK = 4'hD;
   localparam logic [3:0] CMD_SECTOR = 4'hB;
   localparam logic [3:0] CMD_BYTE = 4'hE;
   localparam logic [3:0] CMD_BURST = 4'h6;
   localparam logic [3:0] CMD_VERIFY = 4'hC;
   localparam logic [3:0] CMD_SB1 = 4'hF;
   localparam logic [3:0] CMD_SB2 = 4'h3;
   localparam logic [3:0] CMD_SB3 = 4'h5;
   localparam logic [3:0] CMD_RB0 = 4'h8;
   localparam logic [3:0] CMD_RB1 = 4'h9;

   // ----------------------------------------
   // array layout
   // ----------------------------------------
   localparam int MEM_BYTES = 36864;
   localparam logic [15:0] BLK1_BASE = 16'h8000;
   localparam logic [15:0] BLK0_END_32K = 16'h7FFF;
   localparam logic [15:0] BLK0_END_16K = 16'h3FFF;
   localparam logic [15:0] MEM_LAST = 16'h8FFF;
   localparam logic [15:0] SECTOR0_MASK = 16'h007F;
   localparam logic [15:0] SECTOR1_MASK = 16'h003F;
   localparam logic [3:0] BLK1_TAG = 4'hF;
   localparam logic [7:0] ERASED = 8'hFF;
   localparam logic [7:0] LOCKED_READ = 8'h00;
   localparam logic [15:0] ID_MFR_ADDR = 16'h0030;
   localparam logic [15:0] ID_DEV_ADDR = 16'h0031;

   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [7:0] STATUS_OFS = 8'h00;
   localparam logic [7:0] CONFIG_OFS = 8'h04;
   localparam logic CONFIG_RST = 1'b1;

   typedef enum logic [1:0] {
      ST_IDLE, ST_ERASE, ST_PROG, ST_BURST_WAIT
   } state_t;

   typedef enum logic [2:0] {
      OP_NONE, OP_CHIP, OP_ERASE, OP_BYTE, OP_BURST, OP_BIT
   } op_t;

endpackage

// file: hw/host_flash_port.sv
`timescale 1ns/10ps
// How it works
// - select falling while reset pin high enters host mode, pins reassigned
// - identity read held 1 ms arms; unarmed, other commands ignored
// - erase and program start on strobe falling edge, timed internally
// - identity read and verify served at any strobe level
// - chip erase clears both blocks, security and remap bits, ignoring lock
// - block erase: A15=0 primary, A[15:12]=1111b secondary; locked refused
// - sectors 128 bytes primary, 64 bytes secondary F000H-FFFFH
// - sector erase picks sector by address; refused if block locked
// - byte and burst program leave array untouched when locked
// - byte program writes one byte; burst writes a row byte by byte
// - verify returns stored byte, disabled when block locked
// - security and remap commands set bits, cleared only by chip erase or presetn
// - oscillator runs only while in host mode
// - core held in reset throughout host mode
// - ready/busy falls after strobe starts operation, rises on completion
// - ready rises after each burst byte; host sends next before timeout
// - burst byte arriving while busy is kept and programmed in next cycle
// - verify while programming returns complemented bits 7 and 3, others 0
// - burst: bit 7 true per byte done, bit 3 true after burst end
// - locked array reads return 00H
// - burst ends on row change, new strobe command or 20 us timeout
// - mode holds while reset high and select low; command acts on strobe
// - command codes decoded from four control pins
// - security and remap codes decoded; other codes invalid
// - data on port 0, address on port 1, port 2 low and port 3 bits
module host_flash_port
   import flash_host_pkg::*;
#(
   parameter int ARM_CYCLES = ARM_CYCLES_DEF,
   parameter logic [7:0] MFR_ID = 8'h5A, // arbitrary value
   parameter logic [7:0] DEV_ID = 8'hA5  // arbitrary value
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rst_pin,
   input wire logic host_mode_select_n,
   input wire logic prog_n,
   input wire logic external_access_n,
   input wire logic [3:0] cmd_code,
   input wire logic [15:0] addr_in,
   input wire logic [7:0] data_in,
   output logic [7:0] data_out,
   output logic data_oe,
   output logic ready_busy,
   output logic core_reset,
   output logic osc_enable,
   output logic host_mode
);

   logic [7:0] mem [0:MEM_BYTES-1];
   logic mode_q, sel_q, prog_q, armed_q;
   logic [17:0] arm_cnt_q;
   state_t state_q;
   op_t op_q;
   logic [15:0] idx_q, end_q, paddr_q;
   logic [7:0] pdata_q, dout_q, last_q;
   logic [11:0] tmo_q;
   logic [7:0] tmr_q;
   logic [3:0] bitcmd_q;
   logic [3:1] sb_q;
   logic [1:0] remap_q;
   logic pend_q;
   logic [3:0] pend_cmd_q;
   logic [15:0] pend_addr_q;
   logic [7:0] pend_data_q;
   logic size32_q, ready_q, oe_q;
   logic [31:0] prdata_q;

   // ----------------------------------------
   // address helpers
   // ----------------------------------------
   function automatic logic in_blk0(input logic [15:0] a, input logic s32);
      in_blk0 = !a[15] && (s32 || !a[14]);
   endfunction

   function automatic logic in_blk1(input logic [15:0] a);
      in_blk1 = (a[15:12] == BLK1_TAG);
   endfunction

   function automatic logic [15:0] to_idx(input logic [15:0] a);
      to_idx = in_blk1(a) ? (BLK1_BASE | {4'h0, a[11:0]}) : {1'b0, a[14:0]};
   endfunction

   // rows are half a sector: 64 bytes primary, 32 bytes secondary
   function automatic logic same_row(input logic [15:0] a,
                                     input logic [15:0] b);
      same_row = in_blk1(a) ? (a[15:5] == b[15:5]) : (a[15:6] == b[15:6]);
   endfunction

   logic lock_any;
   logic strobe, ev;
   logic [3:0] ev_cmd;
   logic [15:0] ev_addr;
   logic [7:0] ev_data;
   logic ev_valid, prog_busy;

   // one lock for both blocks; any security bit closes the array
   assign lock_any = |sb_q;
   assign core_reset = rst_pin | mode_q;
   assign osc_enable = mode_q;
   assign host_mode = mode_q;
   assign data_out = dout_q;
   assign data_oe = oe_q;
   assign ready_busy = ready_q;

   // ----------------------------------------
   // mode entry and arming
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= 1'b0;
         sel_q <= 1'b1;
         prog_q <= 1'b1;
      end else begin
         sel_q <= host_mode_select_n;
         prog_q <= prog_n;
         if (!rst_pin || host_mode_select_n) begin
            mode_q <= 1'b0;
         end else if (sel_q && !host_mode_select_n) begin
            mode_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         armed_q <= 1'b0;
         arm_cnt_q <= '0;
      end else if (!mode_q) begin
         armed_q <= 1'b0;
         arm_cnt_q <= '0;
      end else if (!armed_q && prog_n && cmd_code == CMD_ID) begin
         if (arm_cnt_q == 18'(ARM_CYCLES - 1)) begin
            armed_q <= 1'b1;
         end
         arm_cnt_q <= arm_cnt_q + 18'd1;
      end else begin
         arm_cnt_q <= '0;
      end
   end

   // ----------------------------------------
   // command events
   // ----------------------------------------
   // commands need ea high; unarmed strobes vanish here
   assign strobe = mode_q && armed_q && external_access_n
                   && prog_q && !prog_n;
   assign ev = strobe || pend_q;
   assign ev_cmd = strobe ? cmd_code : pend_cmd_q;
   assign ev_addr = strobe ? addr_in : pend_addr_q;
   assign ev_data = strobe ? data_in : pend_data_q;
   assign ev_valid = in_blk0(ev_addr, size32_q) || in_blk1(ev_addr);
   assign prog_busy = (state_q == ST_PROG) && op_q != OP_BIT;

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_IDLE;
         op_q <= OP_NONE;
         idx_q <= '0;
         end_q <= '0;
         paddr_q <= '0;
         pdata_q <= ERASED;
         last_q <= ERASED;
         tmr_q <= '0;
         tmo_q <= '0;
         bitcmd_q <= '0;
      end else if (!mode_q) begin
         state_q <= ST_IDLE;
         op_q <= OP_NONE;
      end else begin
         case (state_q)
            ST_IDLE, ST_BURST_WAIT: begin
               tmo_q <= tmo_q + 12'd1;
               if (ev && state_q == ST_BURST_WAIT && ev_cmd == CMD_BURST
                   && same_row(ev_addr, paddr_q)) begin
                  state_q <= ST_PROG;
                  paddr_q <= ev_addr;
                  pdata_q <= ev_data;
                  last_q <= ev_data;
                  tmr_q <= '0;
               end else if (ev) begin
                  state_q <= ST_IDLE;
                  op_q <= OP_NONE;
                  tmr_q <= '0;
                  paddr_q <= ev_addr;
                  pdata_q <= ev_data;
                  case (ev_cmd)
                     CMD_CHIP: begin
                        state_q <= ST_ERASE;
                        op_q <= OP_CHIP;
                        idx_q <= '0;
                        end_q <= MEM_LAST;
                     end
                     CMD_BLOCK: begin
                        if (!lock_any && !ev_addr[15]) begin
                           state_q <= ST_ERASE;
                           op_q <= OP_ERASE;
                           idx_q <= '0;
                           end_q <= size32_q ? BLK0_END_32K : BLK0_END_16K;
                        end else if (!lock_any && in_blk1(ev_addr)) begin
                           state_q <= ST_ERASE;
                           op_q <= OP_ERASE;
                           idx_q <= BLK1_BASE;
                           end_q <= MEM_LAST;
                        end
                     end
                     CMD_SECTOR: begin
                        if (!lock_any && ev_valid) begin
                           state_q <= ST_ERASE;
                           op_q <= OP_ERASE;
                           if (in_blk1(ev_addr)) begin
                              idx_q <= to_idx(ev_addr) & ~SECTOR1_MASK;
                              end_q <= to_idx(ev_addr) | SECTOR1_MASK;
                           end else begin
                              idx_q <= to_idx(ev_addr) & ~SECTOR0_MASK;
                              end_q <= to_idx(ev_addr) | SECTOR0_MASK;
                           end
                        end
                     end
                     CMD_BYTE, CMD_BURST: begin
                        if (!lock_any && ev_valid) begin
                           state_q <= ST_PROG;
                           op_q <= (ev_cmd == CMD_BURST) ? OP_BURST
                                                         : OP_BYTE;
                           last_q <= ev_data;
                        end
                     end
                     CMD_SB1, CMD_SB2, CMD_SB3, CMD_RB0, CMD_RB1: begin
                        state_q <= ST_PROG;
                        op_q <= OP_BIT;
                        bitcmd_q <= ev_cmd;
                     end
                     default: begin
                     end
                  endcase
               end else if (state_q == ST_BURST_WAIT
                            && tmo_q == 12'(BURST_TIMEOUT_CYC - 1)) begin
                  state_q <= ST_IDLE;
                  op_q <= OP_NONE;
               end
            end
            ST_ERASE: begin
               idx_q <= idx_q + 16'd1;
               if (idx_q == end_q) begin
                  state_q <= ST_IDLE;
               end
            end
            ST_PROG: begin
               tmr_q <= tmr_q + 8'd1;
               if (tmr_q == 8'(PROG_CYC - 1)) begin
                  tmo_q <= '0;
                  if (op_q == OP_BURST) begin
                     state_q <= ST_BURST_WAIT;
                  end else begin
                     state_q <= ST_IDLE;
                  end
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // burst bytes strobed while busy wait for the next cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_q <= 1'b0;
         pend_cmd_q <= '0;
         pend_addr_q <= '0;
         pend_data_q <= '0;
      end else if (strobe && state_q == ST_PROG && op_q == OP_BURST) begin
         pend_q <= 1'b1;
         pend_cmd_q <= cmd_code;
         pend_addr_q <= addr_in;
         pend_data_q <= data_in;
      end else if (state_q != ST_PROG || !mode_q) begin
         pend_q <= 1'b0;
      end
   end

   // ----------------------------------------
   // nonvolatile bits and array
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sb_q <= '0;
         remap_q <= '0;
      end else if (state_q == ST_ERASE && op_q == OP_CHIP
                   && idx_q == end_q) begin
         sb_q <= '0;
         remap_q <= '0;
      end else if (state_q == ST_PROG && op_q == OP_BIT
                   && tmr_q == 8'(PROG_CYC - 1)) begin
         case (bitcmd_q)
            CMD_SB1: sb_q[1] <= 1'b1;
            CMD_SB2: sb_q[2] <= 1'b1;
            CMD_SB3: sb_q[3] <= 1'b1;
            CMD_RB0: remap_q[0] <= 1'b1;
            CMD_RB1: remap_q[1] <= 1'b1;
            default: begin
            end
         endcase
      end
   end

   logic mem_we;
   logic [15:0] mem_wi;
   logic [7:0] mem_wd;

   always_comb begin
      mem_we = 1'b0;
      mem_wi = idx_q;
      mem_wd = ERASED;
      if (mode_q && state_q == ST_ERASE) begin
         mem_we = 1'b1;
      end else if (mode_q && prog_busy && tmr_q == 8'(PROG_CYC - 1)) begin
         mem_we = 1'b1;
         mem_wi = to_idx(paddr_q);
         // programming can only clear bits
         mem_wd = mem[to_idx(paddr_q)] & pdata_q;
      end
   end

   always_ff @(posedge pclk) begin
      if (mem_we) begin
         mem[mem_wi] <= mem_wd;
      end
   end

   // ----------------------------------------
   // read path and ready
   // ----------------------------------------
   logic [7:0] rd_val;
   logic rd_cmd;

   assign rd_cmd = (cmd_code == CMD_ID) || (cmd_code == CMD_VERIFY);

   always_comb begin
      rd_val = LOCKED_READ;
      if (cmd_code == CMD_ID) begin
         if (addr_in == ID_MFR_ADDR) begin
            rd_val = MFR_ID;
         end else if (addr_in == ID_DEV_ADDR) begin
            rd_val = DEV_ID;
         end
      end else if (!armed_q) begin
         rd_val = LOCKED_READ;
      end else if (prog_busy) begin
         rd_val = {~last_q[7], 3'b000, ~last_q[3], 3'b000};
      end else if (state_q == ST_BURST_WAIT) begin
         rd_val = {last_q[7], 3'b000, ~last_q[3], 3'b000};
      end else if (lock_any) begin
         rd_val = LOCKED_READ;
      end else if (state_q == ST_IDLE && (in_blk0(addr_in, size32_q)
                                        || in_blk1(addr_in))) begin
         rd_val = mem[to_idx(addr_in)];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dout_q <= LOCKED_READ;
         oe_q <= 1'b0;
         ready_q <= 1'b1;
      end else begin
         dout_q <= rd_val;
         oe_q <= mode_q && rd_cmd;
         ready_q <= !(state_q == ST_ERASE || state_q == ST_PROG);
      end
   end

   // ----------------------------------------
   // apb registers
   // ----------------------------------------
   logic hit;

   assign hit = (paddr == STATUS_OFS) || (paddr == CONFIG_OFS);
   assign pready = 1'b1;
   assign pslverr = psel && penable && !hit;
   assign prdata = prdata_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         size32_q <= CONFIG_RST;
         prdata_q <= '0;
      end else begin
         if (psel && penable && pwrite && paddr == CONFIG_OFS) begin
            size32_q <= pwdata[0];
         end
         if (psel && !penable) begin
            prdata_q <= '0;
            if (paddr == STATUS_OFS) begin
               prdata_q <= {24'h0, mode_q, armed_q, !ready_q,
                            remap_q, sb_q};
            end else if (paddr == CONFIG_OFS) begin
               prdata_q <= {31'h0, size32_q};
            end
         end
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_mode_exit;
      @(posedge pclk) disable iff (!presetn)
      !rst_pin |=> !mode_q;
   endproperty
   a_mode_exit: assert property (p_mode_exit)
      else $error("host mode held with reset pin low");

   property p_osc_off;
      @(posedge pclk) disable iff (!presetn)
      // arming drops one edge after the mode flag
      $fell(mode_q) |-> !osc_enable ##1 !armed_q;
   endproperty
   a_osc_off: assert property (p_osc_off)
      else $error("oscillator left running after exit");

   property p_unarmed;
      @(posedge pclk) disable iff (!presetn)
      (!armed_q && state_q == ST_IDLE) |=> state_q == ST_IDLE;
   endproperty
   a_unarmed: assert property (p_unarmed)
      else $error("command accepted before arming");

   property p_arm_time;
      @(posedge pclk) disable iff (!presetn)
      $rose(armed_q) |-> $past(arm_cnt_q) == 18'(ARM_CYCLES - 1);
   endproperty
   a_arm_time: assert property (p_arm_time)
      else $error("armed before identity read held long enough");

   property p_busy_low;
      @(posedge pclk) disable iff (!presetn)
      (state_q == ST_IDLE ##1 state_q == ST_PROG) |=> !ready_busy;
   endproperty
   a_busy_low: assert property (p_busy_low)
      else $error("ready not low after program start");

   property p_burst_tmo;
      @(posedge pclk) disable iff (!presetn)
      (mode_q && state_q == ST_BURST_WAIT && !ev
       && tmo_q == 12'(BURST_TIMEOUT_CYC - 1)) |=> state_q == ST_IDLE;
   endproperty
   a_burst_tmo: assert property (p_burst_tmo)
      else $error("burst did not end on timeout");

   property p_lock_write;
      @(posedge pclk) disable iff (!presetn)
      (mem_we && state_q == ST_PROG) |-> !lock_any;
   endproperty
   a_lock_write: assert property (p_lock_write)
      else $error("locked array programmed");

   property p_chip_clear;
      @(posedge pclk) disable iff (!presetn)
      (state_q == ST_ERASE && op_q == OP_CHIP && idx_q == end_q)
         |=> sb_q == 3'b000 && remap_q == 2'b00;
   endproperty
   a_chip_clear: assert property (p_chip_clear)
      else $error("chip erase left security or remap bits");

   property p_poll;
      @(posedge pclk) disable iff (!presetn)
      (prog_busy && cmd_code == CMD_VERIFY && armed_q)
         |=> data_out[6:4] == 3'b000 && data_out[2:0] == 3'b000
             && data_out[7] == ~last_q[7];
   endproperty
   a_poll: assert property (p_poll)
      else $error("polling data wrong while busy");

   property p_locked_read;
      @(posedge pclk) disable iff (!presetn)
      (state_q == ST_IDLE && lock_any && cmd_code == CMD_VERIFY)
         |=> data_out == LOCKED_READ;
   endproperty
   a_locked_read: assert property (p_locked_read)
      else $error("locked read did not return zero");

endmodule

// file: tb/external_host_flash_programming_test.sv
`timescale 1ns/10ps
module external_host_flash_programming_test;
   import flash_host_pkg::*;
   localparam int ARM_N = 8;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, b;
   logic [7:0] paddr, data_in, data_out;
   logic [31:0] pwdata, prdata, rd;
   logic rst_pin, host_mode_select_n, prog_n, external_access_n;
   logic [3:0] cmd_code;
   logic [15:0] addr_in;
   logic data_oe, ready_busy, core_reset, osc_enable, host_mode;
   logic [3:0] set_cmds [5] = '{CMD_SB1, CMD_SB2, CMD_SB3, CMD_RB0, CMD_RB1};
   logic [3:0] lock_cmds [3] = '{CMD_BYTE, CMD_SECTOR, CMD_BLOCK};
   int miscompares = 0;
   int checks_done = 0;
   // id value is arbitrary
   host_flash_port #(.ARM_CYCLES(ARM_N), .MFR_ID(8'h6B)) uut (.*);
   host_programmer host (.*);
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   // ---------------------------------
   // helpers
   // ---------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= 32'h0;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // bus released by the programmer: inverted last value
   task automatic vf(input logic [15:0] a, input logic [7:0] e);
      host.put(CMD_VERIFY, a, ~data_in);
      repeat (2) @(posedge pclk);
      chk({23'h0, data_oe, data_out}, {23'h0, 1'b1, e});
   endtask
   task automatic op(input logic [3:0] c, input logic [15:0] a,
                     input logic [7:0] d, input logic busy);
      host.put(c, a, d);
      host.pulse();
      host.wait_done(b);
      chk(32'(b), 32'(busy));
   endtask
   task automatic close_out();
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // ---------------------------------
   // sequence
   // ---------------------------------
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, STATUS_OFS);
      chk(rd, 32'h0);
      apb(1'b0, CONFIG_OFS);
      chk(rd, 32'h1);
      apb(1'b1, CONFIG_OFS);
      apb(1'b0, CONFIG_OFS);
      chk(rd, 32'h0);
      apb(1'b0, 8'h08);
      chk({rd[30:0], err}, 32'h1);
      chk(32'({host_mode, osc_enable, core_reset}), 32'h0);
      host.enter(1'b0);
      repeat (2) @(posedge pclk);
      chk(32'({host_mode, osc_enable, core_reset}), 32'h7);
      op(CMD_CHIP, 16'h0, 8'h0, 1'b0);
      host.put(CMD_ID, ID_MFR_ADDR, 8'h00);
      repeat (ARM_N + 2) @(posedge pclk);
      chk(32'({data_oe, data_out}), 32'h16B);
      apb(1'b0, STATUS_OFS);
      chk(rd & 32'hC0, 32'hC0);
      op(CMD_CHIP, 16'h0, 8'h0, 1'b1);
      vf(16'h0010, 8'hFF);
      host.put(CMD_BYTE, 16'h0010, 8'h3C);
      host.pulse();
      vf(16'h0010, 8'h80);
      host.wait_done(b);
      chk(32'(b), 32'h1);
      vf(16'h0010, 8'h3C);
      vf(16'h0011, 8'hFF);
      op(CMD_BYTE, 16'h0080, 8'h00, 1'b1);
      op(CMD_SECTOR, 16'h0010, 8'h0, 1'b1);
      vf(16'h0010, 8'hFF);
      vf(16'h0080, 8'h00);
      op(CMD_BLOCK, 16'h0000, 8'h0, 1'b1);
      vf(16'h0080, 8'hFF);
      op(CMD_BYTE, 16'hF03F, 8'h00, 1'b1);
      op(CMD_BYTE, 16'hF040, 8'h00, 1'b1);
      op(CMD_SECTOR, 16'hF010, 8'h0, 1'b1);
      vf(16'hF03F, 8'hFF);
      vf(16'hF040, 8'h00);
      op(CMD_BLOCK, 16'hF000, 8'h0, 1'b1);
      vf(16'hF040, 8'hFF);
      op(CMD_BURST, 16'h0100, 8'h0F, 1'b1);
      op(CMD_BURST, 16'h0101, 8'hF0, 1'b1);
      vf(16'h0101, 8'h88);
      host.put(CMD_BURST, 16'h0102, 8'h33);
      host.pulse();
      host.put(CMD_BURST, 16'h0103, 8'hCC);
      host.pulse();
      host.wait_done(b);
      host.wait_done(b);
      chk(32'(b), 32'h1);
      repeat (BURST_TIMEOUT_CYC + 20) @(posedge pclk);
      vf(16'h0101, 8'hF0);
      vf(16'h0103, 8'hCC);
      vf(16'h0102, 8'h33);
      op(4'h2, 16'h0100, 8'h00, 1'b0);
      vf(16'h0100, 8'h0F);
      for (int i = 0; i < 5; i++) begin
         op(set_cmds[i], 16'h0, 8'h0, 1'b1);
         apb(1'b0, STATUS_OFS);
         chk(rd & 32'h1F, (32'h2 << i) - 32'h1);
      end
      vf(16'h0100, 8'h00);
      for (int i = 0; i < 3; i++) begin
         op(lock_cmds[i], 16'h0100, 8'h00, 1'b0);
      end
      op(CMD_CHIP, 16'h0, 8'h0, 1'b1);
      apb(1'b0, STATUS_OFS);
      chk(rd & 32'h1F, 32'h0);
      vf(16'h0100, 8'hFF);
      host.enter(1'b1);
      repeat (2) @(posedge pclk);
      chk(32'({host_mode, osc_enable}), 32'h0);
      close_out();
   end
   // about 100k cycles of work expected
   initial begin
      #560000;
      miscompares++;
      close_out();
   end
endmodule

// file: tb/host_programmer.sv
`timescale 1ns/10ps
// ---------------------------------
// programmer pins, changed just after an edge
// ---------------------------------
module host_programmer
   import flash_host_pkg::*;
(
   input wire logic pclk,
   input wire logic ready_busy,
   output logic rst_pin,
   output logic host_mode_select_n,
   output logic prog_n,
   output logic external_access_n,
   output logic [3:0] cmd_code,
   output logic [15:0] addr_in,
   output logic [7:0] data_in
);
   // verify code at start so nothing arms before the bench asks
   initial begin
      rst_pin = 1'b0;
      host_mode_select_n = 1'b1;
      prog_n = 1'b1;
      external_access_n = 1'b1;
      cmd_code = CMD_VERIFY;
      addr_in = 16'h0000;
      data_in = 8'h00;
   end
   task automatic enter(input logic s);
      @(posedge pclk);
      rst_pin <= 1'b1;
      @(posedge pclk);
      host_mode_select_n <= s;
   endtask
   task automatic put(input logic [3:0] c, input logic [15:0] a,
                      input logic [7:0] d);
      @(posedge pclk);
      cmd_code <= c;
      addr_in <= a;
      data_in <= d;
   endtask
   task automatic pulse();
      @(posedge pclk);
      prog_n <= 1'b0;
      @(posedge pclk);
      prog_n <= 1'b1;
   endtask
   // a refused command never shows busy, so only a short look
   task automatic wait_done(output logic seen);
      seen = 1'b0;
      repeat (4) begin
         @(posedge pclk);
         if (ready_busy === 1'b0) seen = 1'b1;
      end
      while (seen && ready_busy !== 1'b1) @(posedge pclk);
   endtask
endmodule
